// ==== hdl/tmc_consts.vh ====
`ifndef TMC_CONSTS_VH
`define TMC_CONSTS_VH

// register byte offsets on the bus
`define TMC_CFG_OFS      8'h00
`define TMC_CMD_OFS      8'h04
`define TMC_STAT_OFS     8'h08
`define TMC_IRQ_STAT_OFS 8'h0C
`define TMC_IRQ_MASK_OFS 8'h10
`define TMC_OFF_DLY_OFS  8'h14

// configuration field
`define TMC_CFG_GEN_BIT  0

// command fields, each a write-one pulse
`define TMC_CMD_LOC_ON   0
`define TMC_CMD_LOC_OFF  1
`define TMC_CMD_TO_N     2
`define TMC_CMD_TO_A     3
`define TMC_CMD_TO_O     4
`define TMC_CMD_ALM_CLR  5

// interrupt event fields
`define TMC_EV_DONE      0
`define TMC_EV_REFUSE    1
`define TMC_EV_INHIB     2
`define TMC_EV_FIRE      3
`define TMC_EV_FORCE     4
`define TMC_EV_HANDLE    5
`define TMC_EV_W         6

// reset values
`define TMC_CFG_RST      1'b0
`define TMC_OFF_DLY_RST  16'h0003
`define TMC_IRQ_MASK_RST 6'h00

// timing: cycles per ms at 50 MHz, 5 ms input filter, fixed return delay
`define TMC_MS_CYC       16'hC350
`define TMC_DB_CYC       20'h3_D090
`define TMC_RET_DLY_MS   16'h0002

`endif

// ==== hdl/tmc_mode_ctrl.v ====
// The address map and the AHB-Lite slave port were left to the implementer.
`timescale 1ns/10ps
`include "tmc_consts.vh"

// two-flop synchroniser followed by a stability filter
module tmc_filt #(
  parameter [19:0] DB = 20'h0_0002       // cycles the level must hold
) (
  input  wire clk,                       // controller clock
  input  wire rst,                       // asynchronous reset
  input  wire din,                       // raw pin level
  output reg  dout                       // filtered level
);
  reg        s1_q;                       // first stage, read by s2_q only
  reg        s2_q;                       // second stage
  reg [19:0] cnt_q;                      // stability counter

  // new level accepted only after it stood for DB cycles
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s1_q  <= 1'b0;
      s2_q  <= 1'b0;
      dout  <= 1'b0;
      cnt_q <= 20'h0_0000;
    end
    else
    begin
      s1_q <= din;
      s2_q <= s1_q;
      if (s2_q == dout)
        cnt_q <= 20'h0_0000;             // level agrees, restart count
      else if (cnt_q >= DB - 20'h0_0001)
      begin
        dout  <= s2_q;                   // stable long enough
        cnt_q <= 20'h0_0000;
      end
      else
        cnt_q <= cnt_q + 20'h0_0001;
    end
  end
endmodule // tmc_filt

module tmc_mode_ctrl #(
  parameter [15:0] MS_CYCLES = `TMC_MS_CYC,  // cycles per millisecond
  parameter [19:0] DB_CYCLES = `TMC_DB_CYC   // input filter time
) (
  input  wire        CLOCK,
  input  wire        SYS_RST,
  input  wire        HSEL,
  input  wire [31:0] HADDR,
  input  wire [1:0]  HTRANS,
  input  wire        HWRITE,
  input  wire [2:0]  HSIZE,
  input  wire [31:0] HWDATA,
  input  wire        HREADY,
  output reg  [31:0] HRDATA,
  output wire        HREADYOUT,
  output wire        HRESP,
  input  wire        INHIBIT,
  input  wire        FIRE,
  input  wire        FORCE_OFF,
  input  wire        HANDLE,
  input  wire        N_OK,
  input  wire        A_OK,
  input  wire        N_SOL_OK,
  input  wire        A_SOL_OK,
  input  wire        POS_N,
  input  wire        POS_A,
  input  wire        POS_O,
  output reg         ORDER_N,
  output reg         ORDER_A,
  output reg         ORDER_O,
  output reg         LOAD_SHED,
  output reg         GEN_START,
  output reg         ALARM_RELAY,
  output reg         ALARM_LED,
  output reg  [1:0]  POS_IND,
  output reg         INHIB_IND,
  output reg         IRQ
);
  // modes, highest priority last
  localparam [2:0] M_AUTO   = 3'b000;
  localparam [2:0] M_LOCAL  = 3'b001;
  localparam [2:0] M_INHIB  = 3'b010;
  localparam [2:0] M_FIRE   = 3'b011;
  localparam [2:0] M_FORCE  = 3'b100;
  localparam [2:0] M_HANDLE = 3'b101;
  // transfer engine phases
  localparam [1:0] E_IDLE   = 2'b00;
  localparam [1:0] E_OFFD   = 2'b01;
  localparam [1:0] E_GO     = 2'b10;
  // targets and positions share codes
  localparam [1:0] T_N      = 2'b00;
  localparam [1:0] T_A      = 2'b01;
  localparam [1:0] T_O      = 2'b10;
  localparam [1:0] T_AUTO   = 2'b11;

  wire [10:0] raw;                       // pins before filtering
  wire [10:0] flt;                       // pins after filtering
  wire        inhib_s  = flt[0];
  wire        fire_s   = flt[1];
  wire        force_s  = flt[2];
  wire        handle_s = flt[3];
  wire        n_ok     = flt[4];
  wire        a_ok     = flt[5];
  wire        n_sol    = flt[6];
  wire        a_sol    = flt[7];
  reg  [1:0]  pos;                       // decoded switch position
  assign raw = {POS_O, POS_A, POS_N, A_SOL_OK, N_SOL_OK, A_OK, N_OK,
                HANDLE, FORCE_OFF, FIRE, INHIBIT};
  // every pin synchronised; mode inputs also debounced
  genvar gi;
  generate
    for (gi = 0; gi < 11; gi = gi + 1)
    begin : g_in
      tmc_filt #(
        .DB   ((gi < 4) ? DB_CYCLES : 20'h0_0001)
      ) u_filt (
        .clk  (CLOCK),
        .rst  (SYS_RST),
        .din  (raw[gi]),
        .dout (flt[gi])
      );
    end
  endgenerate

  // position from the mechanism contacts
  always @*
  begin
    if (flt[8])
      pos = T_N;
    else if (flt[9])
      pos = T_A;
    else if (flt[10])
      pos = T_O;
    else
      pos = T_AUTO;                      // between positions
  end

  // ---------------- bus slave ----------------
  reg        wr_q;                       // write data phase pending
  reg [7:0]  adr_q;                      // latched byte offset
  reg        gen_cfg_q;                  // utility-generator configuration
  reg [15:0] off_dly_q;                  // off delay in ms
  reg [`TMC_EV_W-1:0] ist_q;             // sticky event bits
  reg [`TMC_EV_W-1:0] imask_q;           // interrupt enables
  wire       aph = HSEL & HREADY & HTRANS[1];
  wire       cmd_wr = wr_q & (adr_q == `TMC_CMD_OFS);
  wire [5:0] cmd = cmd_wr ? HWDATA[5:0] : 6'h00;
  assign HREADYOUT = 1'b1;               // zero wait states
  assign HRESP     = 1'b0;               // always OKAY
  // ---------------- mode and engine state ----------------
  reg [2:0]  mode_q;                     // active mode
  reg [2:0]  mode_d;                     // arbitrated next mode
  reg        local_q;                    // local control selected
  reg        boot_q;                     // first cycle after reset
  reg [1:0]  eph_q;                      // engine phase
  reg [1:0]  tgt_q;                      // engine target
  reg [15:0] lim_q;                      // delay length in ms
  reg [15:0] div_q;                      // millisecond prescaler
  reg [15:0] msc_q;                      // elapsed ms
  reg        shed_q;                     // load shedding state
  reg        gen_q;                      // generator start state
  reg        alarm_q;                    // alarm latch

  wire busy     = (eph_q != E_IDLE);
  wire ms_tick  = (div_q == MS_CYCLES - 16'h0001);
  wire dly_end  = (eph_q == E_OFFD) & (msc_q >= lim_q);
  wire refuse   = (~n_ok & ~a_ok) | (~n_sol & ~a_sol);
  wire in_loc   = (mode_q == M_LOCAL);
  wire loc_n    = in_loc & cmd[`TMC_CMD_TO_N];
  wire loc_a    = in_loc & cmd[`TMC_CMD_TO_A];
  wire loc_o    = in_loc & cmd[`TMC_CMD_TO_O];
  wire refused  = (loc_n | loc_a) & refuse;
  wire auto_ent = (mode_d == M_AUTO) & ((mode_q != M_AUTO) | boot_q);
  wire done     = (eph_q == E_GO) & (pos == tgt_q);
  wire [`TMC_EV_W-1:0] ev;
  assign ev = {(mode_d == M_HANDLE) & (mode_q != M_HANDLE),
               (mode_d == M_FORCE)  & (mode_q != M_FORCE),
               (mode_d == M_FIRE)   & (mode_q != M_FIRE),
               (mode_d == M_INHIB)  & (mode_q != M_INHIB),
               refused, done};
  // mode arbitration by priority
  always @*
  begin
    mode_d = local_q ? M_LOCAL : M_AUTO;
    if (handle_s)
      mode_d = M_HANDLE;
    else if (force_s)
      mode_d = M_FORCE;
    else if (fire_s)
      mode_d = M_FIRE;
    else if (inhib_s & ((mode_q >= M_INHIB) | ~busy))
      mode_d = M_INHIB;
  end

  // bus registers, read data and interrupt status
  always @(posedge CLOCK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      wr_q      <= 1'b0;
      adr_q     <= 8'h00;
      HRDATA    <= 32'h0000_0000;
      gen_cfg_q <= `TMC_CFG_RST;
      off_dly_q <= `TMC_OFF_DLY_RST;
      ist_q     <= {`TMC_EV_W{1'b0}};
      imask_q   <= `TMC_IRQ_MASK_RST;
      IRQ       <= 1'b0;
    end
    else
    begin
      wr_q  <= aph & HWRITE;
      adr_q <= aph ? {HADDR[7:2], 2'b00} : adr_q;
      if (aph & ~HWRITE)
      begin
        // read data prepared for the data phase; unmapped reads zero
        case ({HADDR[7:2], 2'b00})
          `TMC_CFG_OFS:      HRDATA <= {31'h0000_0000, gen_cfg_q};
          `TMC_STAT_OFS:     HRDATA <= {17'h0_0000, a_ok, n_ok, alarm_q, gen_q,
                                        shed_q, tgt_q, pos, eph_q, local_q, mode_q};
          `TMC_IRQ_STAT_OFS: HRDATA <= {26'h000_0000, ist_q};
          `TMC_IRQ_MASK_OFS: HRDATA <= {26'h000_0000, imask_q};
          `TMC_OFF_DLY_OFS:  HRDATA <= {16'h0000, off_dly_q};
          default:           HRDATA <= 32'h0000_0000;
        endcase
      end
      if (wr_q & (adr_q == `TMC_CFG_OFS))
        gen_cfg_q <= HWDATA[`TMC_CFG_GEN_BIT];
      if (wr_q & (adr_q == `TMC_IRQ_MASK_OFS))
        imask_q <= HWDATA[`TMC_EV_W-1:0];
      if (wr_q & (adr_q == `TMC_OFF_DLY_OFS))
        off_dly_q <= HWDATA[15:0];
      // write one clears; a new event in the same cycle wins
      if (wr_q & (adr_q == `TMC_IRQ_STAT_OFS))
        ist_q <= (ist_q & ~HWDATA[`TMC_EV_W-1:0]) | ev;
      else
        ist_q <= ist_q | ev;
      IRQ <= |(ist_q & imask_q);
    end
  end

  // mode, local selection and transfer engine
  always @(posedge CLOCK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      mode_q  <= M_AUTO;
      local_q <= 1'b0;
      boot_q  <= 1'b1;
      eph_q   <= E_IDLE;
      tgt_q   <= T_O;
      lim_q   <= 16'h0000;
      div_q   <= 16'h0000;
      msc_q   <= 16'h0000;
      shed_q  <= 1'b0;
      alarm_q <= 1'b0;
    end
    else
    begin
      mode_q <= mode_d;
      boot_q <= 1'b0;
      // delay timer runs only while waiting in off
      div_q <= ((eph_q != E_OFFD) | ms_tick) ? 16'h0000 : div_q + 16'h0001;
      if (eph_q != E_OFFD)
        msc_q <= 16'h0000;
      else if (ms_tick)
        msc_q <= msc_q + 16'h0001;
      // local control is entered only by command from auto
      if (cmd[`TMC_CMD_LOC_ON] & (mode_q == M_AUTO))
        local_q <= 1'b1;
      else if ((cmd[`TMC_CMD_LOC_OFF] & in_loc) | fire_s | force_s)
        local_q <= 1'b0;
      // alarm: refusal sets, software clears, set wins
      if (refused)
        alarm_q <= 1'b1;
      else if (cmd[`TMC_CMD_ALM_CLR])
        alarm_q <= 1'b0;
      if (mode_d >= M_INHIB)
        eph_q <= E_IDLE;                 // cancelled or suspended
      else if (loc_o)
      begin
        tgt_q <= T_O;                    // off at once, no delay
        eph_q <= E_GO;
      end
      else if ((loc_n | loc_a) & ~refuse)
      begin
        tgt_q <= loc_n ? T_N : T_A;
        lim_q <= off_dly_q;              // only the off delay
        eph_q <= (pos == (loc_n ? T_N : T_A)) ? E_IDLE : E_OFFD;
      end
      else if (auto_ent | ((mode_d == M_AUTO) & ~busy & (pos == T_O) & (n_ok | a_ok)))
      begin
        tgt_q <= T_AUTO;                 // interim off, fixed delay
        lim_q <= `TMC_RET_DLY_MS;
        eph_q <= E_OFFD;
      end
      else if ((mode_d == M_AUTO) & ~busy &
               (((pos == T_N) & ~n_ok) | ((pos == T_A) & ~a_ok)))
      begin
        tgt_q <= T_AUTO;                 // source lost: off delay first
        lim_q <= off_dly_q;
        eph_q <= E_OFFD;
      end
      else if (dly_end)
      begin
        if (tgt_q != T_AUTO)
          eph_q <= E_GO;
        else if (n_ok)
        begin
          tgt_q  <= T_N;
          shed_q <= 1'b0;
          eph_q  <= E_GO;
        end
        else if (a_ok)
        begin
          tgt_q  <= T_A;
          shed_q <= 1'b1;                // shed load toward alternate
          eph_q  <= E_GO;
        end
        else
          eph_q <= E_IDLE;               // stay in interim off
      end
      else if (done)
        eph_q <= E_IDLE;
    end
  end

  // generator start follows normal loss in auto only
  always @(posedge CLOCK or posedge SYS_RST)
  begin
    if (SYS_RST)
      gen_q <= 1'b0;
    else if (mode_q == M_AUTO)
      gen_q <= gen_cfg_q & ~n_ok;
    else if (mode_q == M_LOCAL)
      gen_q <= 1'b0;
  end

  // registered outputs to the mechanism and the panel
  always @(posedge CLOCK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      ORDER_N     <= 1'b0;
      ORDER_A     <= 1'b0;
      ORDER_O     <= 1'b0;
      LOAD_SHED   <= 1'b0;
      GEN_START   <= 1'b0;
      ALARM_RELAY <= 1'b0;
      ALARM_LED   <= 1'b0;
      POS_IND     <= 2'b11;
      INHIB_IND   <= 1'b0;
    end
    else
    begin
      POS_IND   <= pos;                  // kept in every mode
      ALARM_LED <= alarm_q;
      INHIB_IND <= (mode_q == M_INHIB);  // panel lock and display
      ORDER_O     <= 1'b0;               // no order unless the mode asks for one
      ORDER_N     <= 1'b0;
      ORDER_A     <= 1'b0;
      ALARM_RELAY <= alarm_q;
      case (mode_q)
        M_AUTO, M_LOCAL:
        begin
          ORDER_O <= (eph_q == E_OFFD) | ((eph_q == E_GO) & (tgt_q == T_O));
          ORDER_N <= (eph_q == E_GO) & (tgt_q == T_N) & n_ok;
          ORDER_A <= (eph_q == E_GO) & (tgt_q == T_A) & a_ok;
          LOAD_SHED   <= in_loc ? 1'b0 : shed_q;
          GEN_START   <= in_loc ? 1'b0 : gen_q;
        end
        M_FIRE, M_FORCE: ORDER_O <= 1'b1;  // emergency off
        M_HANDLE: ALARM_RELAY <= 1'b0;     // suspended, shed and generator held
        default: ORDER_O <= 1'b0;          // inhibit: no orders
      endcase
    end
  end
endmodule // tmc_mode_ctrl

// ==== tb/tmc_sva.sv ====
`timescale 1ns/10ps
module tmc_sva #(
  parameter [15:0] MS_CYCLES = 16'h0004,
  parameter [19:0] DB_CYCLES = 20'h0_0003
) (
  input wire CLOCK,
  input wire SYS_RST,
  input wire INHIBIT,
  input wire FIRE,
  input wire FORCE_OFF,
  input wire HANDLE,
  input wire N_OK,
  input wire A_OK,
  input wire ORDER_N,
  input wire ORDER_A,
  input wire ORDER_O,
  input wire LOAD_SHED,
  input wire GEN_START,
  input wire ALARM_RELAY,
  input wire INHIB_IND,
  input wire IRQ
);
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (SYS_RST);
  // held emergency inputs end in an off order, filter latency allowed
  fire_off_a: assert property ((FIRE && !HANDLE)[*8] |-> ##[0:6] ORDER_O)
    else $error("fire input gave no off order");
  force_off_a: assert property ((FORCE_OFF && !HANDLE)[*8] |-> ##[0:6] ORDER_O)
    else $error("force input gave no off order");
  // one position ordered at a time
  order_excl_a: assert property ($onehot0({ORDER_N, ORDER_A, ORDER_O}))
    else $error("two orders at once");
  // no order toward a source out of tolerance
  n_tol_a: assert property (!N_OK[*6] |-> ##1 !ORDER_N)
    else $error("normal ordered while out of tolerance");
  a_tol_a: assert property (!A_OK[*6] |-> ##1 !ORDER_A)
    else $error("alternate ordered while out of tolerance");
  // inhibit display blocks source orders and ends with the input
  inhib_blk_a: assert property (INHIB_IND |-> !ORDER_N && !ORDER_A)
    else $error("source order while inhibited");
  inhib_end_a: assert property (!INHIBIT[*8] |-> ##1 !INHIB_IND)
    else $error("inhibit shown after input dropped");
  // handle freezes shedding and generator, no relay, no orders
  handle_hold_a: assert property (HANDLE[*8] |-> ##1
    $stable(LOAD_SHED) && $stable(GEN_START) && !ALARM_RELAY)
    else $error("outputs moved under handle");
  handle_idle_a: assert property (HANDLE[*8] |-> ##1 !(ORDER_N || ORDER_A || ORDER_O))
    else $error("order under handle");
  cover property (ORDER_A && LOAD_SHED);
  cover property (INHIB_IND && ORDER_O);
  cover property ($rose(IRQ));
endmodule // tmc_sva

bind tmc_mode_ctrl tmc_sva #(.MS_CYCLES(MS_CYCLES), .DB_CYCLES(DB_CYCLES)) u_sva (
  .CLOCK(CLOCK), .SYS_RST(SYS_RST), .INHIBIT(INHIBIT), .FIRE(FIRE),
  .FORCE_OFF(FORCE_OFF), .HANDLE(HANDLE), .N_OK(N_OK), .A_OK(A_OK),
  .ORDER_N(ORDER_N), .ORDER_A(ORDER_A), .ORDER_O(ORDER_O), .LOAD_SHED(LOAD_SHED),
  .GEN_START(GEN_START), .ALARM_RELAY(ALARM_RELAY), .INHIB_IND(INHIB_IND), .IRQ(IRQ));

// ==== tb/tmc_mech.sv ====
`timescale 1ns/10ps
// switching mechanism: opens on a new order, closes at the target
module tmc_mech (
  input  wire clk,
  input  wire rst,
  input  wire slow,
  input  wire ord_n,
  input  wire ord_a,
  input  wire ord_o,
  output wire pos_n,
  output wire pos_a,
  output wire pos_o
);
  wire [2:0] ord_w = {ord_n, ord_a, ord_o};  // current order
  reg  [2:0] pos_q;                          // contacts, all low in travel
  reg  [2:0] tgt_q;                          // target position
  reg  [4:0] cnt_q;                          // travel cycles left
  assign {pos_n, pos_a, pos_o} = pos_q;
  // travel time is short or long as the bench asks
  always @(posedge clk or posedge rst)
    if (rst)
    begin
      pos_q <= 3'h1;
      tgt_q <= 3'h1;
      cnt_q <= 5'h00;
    end
    else if (ord_w != 3'h0 && ord_w != tgt_q)
    begin
      pos_q <= 3'h0;
      tgt_q <= ord_w;
      cnt_q <= slow ? 5'h14 : 5'h03;
    end
    else if (cnt_q != 5'h00)
      cnt_q <= cnt_q - 5'h01;
    else
      pos_q <= tgt_q;
endmodule // tmc_mech

// ==== tb/tb_top.sv ====
`timescale 1ns/10ps
`include "tmc_consts.vh"
module tb_top;
  reg         clock;
  reg         sys_rst;
  reg         hsel;
  reg  [31:0] haddr;
  reg  [1:0]  htrans;
  reg         hwrite;
  reg  [31:0] hwdata;
  wire [31:0] hrdata;
  wire        hready;
  reg         inhibit, fire, force_off, handle;
  reg         n_ok, a_ok, sol_ok, slow;
  wire        pos_n, pos_a, pos_o, ord_n, ord_a, ord_o;
  wire        shed, gen, alm_rly, alm_led, inh_ind, irq;
  wire [1:0]  pos_ind;
  reg         rd_dp;     // read data phase due
  reg  [31:0] exp_q[$];  // expected read data
  reg  [31:0] rv;
  integer     miscompares, checked, cyc, seed, i, k;

  tmc_mode_ctrl #(.MS_CYCLES(16'h0004), .DB_CYCLES(20'h0_0003)) u_dut (
    .CLOCK(clock), .SYS_RST(sys_rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready),
    .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(), .INHIBIT(inhibit), .FIRE(fire),
    .FORCE_OFF(force_off), .HANDLE(handle), .N_OK(n_ok), .A_OK(a_ok),
    .N_SOL_OK(sol_ok), .A_SOL_OK(sol_ok), .POS_N(pos_n), .POS_A(pos_a),
    .POS_O(pos_o), .ORDER_N(ord_n), .ORDER_A(ord_a), .ORDER_O(ord_o),
    .LOAD_SHED(shed), .GEN_START(gen), .ALARM_RELAY(alm_rly), .ALARM_LED(alm_led),
    .POS_IND(pos_ind), .INHIB_IND(inh_ind), .IRQ(irq));
  tmc_mech u_mech (.clk(clock), .rst(sys_rst), .slow(slow), .ord_n(ord_n),
    .ord_a(ord_a), .ord_o(ord_o), .pos_n(pos_n), .pos_a(pos_a), .pos_o(pos_o));

  always #10 clock = ~clock;

  task chk(input [8*8-1:0] nm, input [31:0] seen, input [31:0] exp);
    begin
      checked = checked + 1;
      if (seen !== exp)
      begin
        miscompares = miscompares + 1;
        $display("MISMATCH %0s exp=%h seen=%h", nm, exp, seen);
      end
    end
  endtask

  task cyc_w(input integer n);
    begin
      repeat (n) @(posedge clock);
      #1;
    end
  endtask

  // one single word transfer; a read notes its expected data
  task ahb(input wr, input [7:0] a, input [31:0] d);
    begin
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= {24'h00_0000, a};
      @(posedge clock);
      while (hready !== 1'b1) @(posedge clock);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      rd_dp <= !wr;
      if (!wr) exp_q.push_back(d);
      @(posedge clock);
      while (hready !== 1'b1) @(posedge clock);
      rd_dp <= 1'b0;
    end
  endtask

  task wait_pos(input [1:0] v);
    begin
      i = 0;
      cyc_w(1);
      while (pos_ind !== v && i < 400)
      begin
        cyc_w(1);
        i = i + 1;
      end
      chk("pos_ind", pos_ind, v);
    end
  endtask

  task print_verdict;
    begin
      $display("checked=%0d miscompares=%0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask

  // read data are compared at the data phase edge
  always @(posedge clock)
    if (rd_dp && hready === 1'b1)
      chk("hrdata", hrdata, exp_q.pop_front());

  // hang guard
  always @(posedge clock)
  begin
    cyc = cyc + 1;
    if (cyc == 20000)
    begin
      miscompares = miscompares + 1;
      print_verdict;
    end
  end

  initial
  begin
    clock = 1'b0;
    sys_rst = 1'b1;
    {hsel, hwrite, rd_dp, slow, htrans} = 6'h00;
    {haddr, hwdata} = 64'h0;
    {inhibit, fire, force_off, handle} = 4'h0;
    {n_ok, a_ok, sol_ok} = 3'h7;
    {miscompares, checked, cyc} = 96'h0;
    seed = 24;
    cyc_w(6);
    chk("pos_ind", pos_ind, 2'h3);
    sys_rst <= 1'b0;
    cyc_w(2);
    chk("ord_o", ord_o, 1'b1);
    cyc_w(4);
    chk("ord_n", ord_n, 1'b0);
    wait_pos(2'h0);
    ahb(0, `TMC_CFG_OFS, `TMC_CFG_RST);
    ahb(0, `TMC_OFF_DLY_OFS, `TMC_OFF_DLY_RST);
    ahb(0, `TMC_IRQ_MASK_OFS, `TMC_IRQ_MASK_RST);
    ahb(0, 8'h18, 32'h0000_0000);
    ahb(0, `TMC_CMD_OFS, 32'h0000_0000);
    for (k = 0; k < 4; k = k + 1)
    begin
      rv = $random(seed);
      ahb(1, `TMC_OFF_DLY_OFS, rv);
      ahb(0, `TMC_OFF_DLY_OFS, {16'h0000, rv[15:0]});
    end
    ahb(1, `TMC_OFF_DLY_OFS, 32'h0000_0001);
    ahb(1, `TMC_CFG_OFS, 32'h0000_0001);
    ahb(1, `TMC_CMD_OFS, 1 << `TMC_CMD_TO_A);
    cyc_w(12);
    chk("pos_ind", pos_ind, 2'h0);
    slow <= 1'b1;
    ahb(1, `TMC_CMD_OFS, 1 << `TMC_CMD_LOC_ON);
    ahb(1, `TMC_CMD_OFS, 1 << `TMC_CMD_TO_A);
    cyc_w(3);
    chk("ord_o", ord_o, 1'b1);
    wait_pos(2'h1);
    chk("shed", shed, 1'b0);
    chk("gen", gen, 1'b0);
    slow <= 1'b0;
    ahb(1, `TMC_CMD_OFS, 1 << `TMC_CMD_TO_N);
    wait_pos(2'h0);
    ahb(1, `TMC_CMD_OFS, 1 << `TMC_CMD_TO_O);
    cyc_w(2);
    chk("ord_o", ord_o, 1'b1);
    wait_pos(2'h2);
    a_ok <= 1'b0;
    cyc_w(6);
    ahb(1, `TMC_CMD_OFS, 1 << `TMC_CMD_TO_A);
    cyc_w(10);
    chk("ord_a", ord_a, 1'b0);
    // drop the transfer still waiting for the alternate source
    ahb(1, `TMC_CMD_OFS, 1 << `TMC_CMD_TO_O);
    ahb(1, `TMC_IRQ_MASK_OFS, 1 << `TMC_EV_REFUSE);
    for (k = 0; k < 2; k = k + 1)
    begin
      {n_ok, a_ok, sol_ok} <= (k == 0) ? 3'h1 : 3'h6;
      cyc_w(6);
      ahb(1, `TMC_CMD_OFS, 1 << `TMC_CMD_TO_N);
      cyc_w(6);
      chk("irq", irq, 1'b1);
      chk("alm_led", alm_led, 1'b1);
      chk("ord_n", ord_n, 1'b0);
      ahb(1, `TMC_IRQ_STAT_OFS, 1 << `TMC_EV_REFUSE);
      if (k == 0) ahb(1, `TMC_CMD_OFS, 1 << `TMC_CMD_ALM_CLR);
      cyc_w(3);
      chk("irq", irq, 1'b0);
      chk("alm_led", alm_led, k != 0);
    end
    {n_ok, a_ok, sol_ok} <= 3'h3;
    cyc_w(6);
    ahb(1, `TMC_CMD_OFS, 1 << `TMC_CMD_LOC_OFF);
    wait_pos(2'h1);
    chk("shed", shed, 1'b1);
    chk("gen", gen, 1'b1);
    chk("alm_rly", alm_rly, 1'b1);
    handle <= 1'b1;
    cyc_w(14);
    n_ok <= 1'b1;
    cyc_w(6);
    chk("gen", gen, 1'b1);
    chk("alm_led", alm_led, 1'b1);
    chk("shed", shed, 1'b1);
    chk("alm_rly", alm_rly, 1'b0);
    chk("orders", {ord_n, ord_a, ord_o}, 3'h0);
    chk("pos_ind", pos_ind, 2'h1);
    handle <= 1'b0;
    wait_pos(2'h0);
    inhibit <= 1'b1;
    cyc_w(12);
    chk("inh_ind", inh_ind, 1'b1);
    fire <= 1'b1;
    cyc_w(10);
    chk("ord_o", ord_o, 1'b1);
    wait_pos(2'h2);
    fire <= 1'b0;
    cyc_w(30);
    chk("pos_ind", pos_ind, 2'h2);
    inhibit <= 1'b0;
    cyc_w(12);
    chk("inh_ind", inh_ind, 1'b0);
    wait_pos(2'h0);
    force_off <= 1'b1;
    cyc_w(10);
    chk("ord_o", ord_o, 1'b1);
    wait_pos(2'h2);
    force_off <= 1'b0;
    wait_pos(2'h0);
    print_verdict;
  end
endmodule // tb_top
